/* File: pkg/sslc_pkg.sv */
package sslc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_FAST_NS = 2000;
  localparam int WAKE_SLOW_NS = 150000;
  localparam int SETTLE_FULL_NS = 2000;
  localparam int SETTLE_NORMAL_NS = 150000;
  // least times, rounded up to whole cycles
  localparam int WAKE_FAST_CYC = (WAKE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_SLOW_CYC = (WAKE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_FULL_CYC = (SETTLE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NORMAL_CYC = (SETTLE_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 18;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_LOW_CTL = 8'h00;
  localparam logic [7:0] OFS_HIGH_CTL = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_SLEEP = 8'h14;

  // flag register bit positions
  localparam int FLG_LOW_SETTLE = 0;
  localparam int FLG_HIGH_SETTLE = 1;
  localparam int FLG_CORE_SUPV = 2;
  localparam int FLG_CORE_MON = 3;
  localparam int FLG_SUPPLY_SUPV = 4;
  localparam int FLG_SUPPLY_MON = 5;
  localparam int FLG_EARLY_ENTRY = 6;
  localparam int FLG_WAKE_DONE = 7;
  localparam int FLG_W = 8;
  localparam logic [7:0] STICKY_BITS = 8'hfc;

  // sleep request register fields
  localparam int SLP_LEVEL_LSB = 0;
  localparam int SLP_ON_EXIT = 2;
  localparam logic [1:0] LEVEL_NONE = 2'h0;

  // per side control word, supvEnable in bit 0
  typedef struct packed {
    logic ovpEnable;
    logic monPorEnable;
    logic supvPorEnable;
    logic autoControl;
    logic monFullPerf;
    logic monEnable;
    logic supvFullPerf;
    logic supvLpmKeep;
    logic supvEnable;
  } sslc_side_ctl_s;
  localparam int CTL_W = 9;
  localparam logic [8:0] LOW_CTL_RST = 9'h041;
  localparam logic [8:0] HIGH_CTL_RST = 9'h041;
  localparam logic [7:0] MASK_RST = 8'h00;

  // comparator trip inputs from the analog side
  typedef struct packed {
    logic overvolt;
    logic supplyMon;
    logic supplySupv;
    logic coreMon;
    logic coreSupv;
  } sslc_trip_s;

  typedef enum logic [1:0] {PERF_OFF, PERF_NORMAL, PERF_FULL} sslc_perf_e;
  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_WAKING} sslc_mode_e;

  // operating state of one supervisor or monitor
  function automatic sslc_perf_e sslc_perf(input logic en, input logic keep,
                                           input logic fp, input logic autoCtl,
                                           input logic deep);
    sslc_perf_e st;
    st = PERF_OFF;
    if (!en) begin
      st = PERF_OFF;
    end else if (!deep) begin
      st = fp ? PERF_FULL : PERF_NORMAL;
    end else if (!keep) begin
      st = PERF_OFF;
    end else if (autoCtl) begin
      st = fp ? PERF_NORMAL : PERF_OFF;
    end else begin
      st = fp ? PERF_FULL : PERF_NORMAL;
    end
    return st;
  endfunction

endpackage

/* File: src/sslc_settle_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module sslc_settle_timer
  import sslc_pkg::*;
#(
  parameter int FAST_CYC = SETTLE_FULL_CYC,
  parameter int SLOW_CYC = SETTLE_NORMAL_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic fullPerf,
  output logic busy
);

  logic [TIMER_W-1:0] count;

  // ****************************************************************
  // countdown
  // ****************************************************************
  // a new write restarts the interval, so the flag tracks the last write
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      busy <= 1'b0;
    end else if (start) begin
      count <= fullPerf ? TIMER_W'(FAST_CYC - 1) : TIMER_W'(SLOW_CYC - 1);
      busy <= 1'b1;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end else begin
      busy <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: src/sslc_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
module sslc_supervisor
  import sslc_pkg::*;
#(
  parameter int WAKE_SLOW = WAKE_SLOW_CYC,
  parameter int SETTLE_SLOW = SETTLE_NORMAL_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wakeIrq,
  input wire logic isrReturn,
  input wire logic programReset,
  input wire sslc_trip_s trip,
  output logic cpuHold,
  output logic deepSleep,
  output logic porRequest,
  output logic irq,
  output logic wakeFast
);

  sslc_side_ctl_s lowCtl;
  sslc_side_ctl_s highCtl;
  logic [FLG_W-1:0] flags;
  logic [FLG_W-1:0] mask;
  logic [1:0] sleepLevel;
  logic sleepOnExit;
  sslc_mode_e mode;
  logic [TIMER_W-1:0] wakeCount;
  logic wakePending;
  logic lowSettle;
  logic highSettle;
  logic setupPhase;
  logic accessPhase;
  logic wrLow;
  logic wrHigh;
  logic wrFlags;
  logic wrMask;
  logic wrSleep;
  logic mapped;
  logic deep;
  logic sleepReq;
  logic autoReq;
  logic enterSleep;
  sslc_perf_e coreSupvSt;
  sslc_perf_e coreMonSt;
  sslc_perf_e supplySupvSt;
  sslc_perf_e supplyMonSt;
  logic [FLG_W-1:0] evtSet;
  logic coreSupvEvt;
  logic coreMonEvt;
  logic supplySupvEvt;
  logic supplyMonEvt;
  logic ovpEvt;
  logic [31:0] rdMux;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // zero wait states; unmapped offsets answer with pslverr
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign mapped = (paddr == OFS_LOW_CTL) || (paddr == OFS_HIGH_CTL) ||
                  (paddr == OFS_FLAGS) || (paddr == OFS_MASK) ||
                  (paddr == OFS_STATUS) || (paddr == OFS_SLEEP);
  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;
  assign wrLow = accessPhase && pwrite && (paddr == OFS_LOW_CTL);
  assign wrHigh = accessPhase && pwrite && (paddr == OFS_HIGH_CTL);
  assign wrFlags = accessPhase && pwrite && (paddr == OFS_FLAGS);
  assign wrMask = accessPhase && pwrite && (paddr == OFS_MASK);
  assign wrSleep = accessPhase && pwrite && (paddr == OFS_SLEEP);

  // read mux, sampled into prdata during the setup cycle
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      OFS_LOW_CTL: rdMux[CTL_W-1:0] = lowCtl;
      OFS_HIGH_CTL: rdMux[CTL_W-1:0] = highCtl;
      OFS_FLAGS: rdMux[FLG_W-1:0] = flags;
      OFS_MASK: rdMux[FLG_W-1:0] = mask;
      OFS_STATUS: rdMux[10:0] = {mode, wakeFast, supplyMonSt, supplySupvSt,
                                 coreMonSt, coreSupvSt};
      OFS_SLEEP: rdMux[2:0] = {sleepOnExit, sleepLevel};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // side control words
  always_ff @(posedge clk) begin
    if (reset) begin
      lowCtl <= LOW_CTL_RST;
      highCtl <= HIGH_CTL_RST;
    end else begin
      if (wrLow) begin
        lowCtl <= pwdata[CTL_W-1:0];
      end
      if (wrHigh) begin
        highCtl <= pwdata[CTL_W-1:0];
      end
    end
  end

  // interrupt mask and sleep request settings
  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= MASK_RST;
      sleepLevel <= LEVEL_NONE;
      sleepOnExit <= 1'b0;
    end else begin
      if (wrMask) begin
        mask <= pwdata[FLG_W-1:0] & STICKY_BITS;
      end
      if (wrSleep) begin
        sleepLevel <= pwdata[SLP_LEVEL_LSB +: 2];
        sleepOnExit <= pwdata[SLP_ON_EXIT];
      end
    end
  end

  // ****************************************************************
  // settle delay flags
  // ****************************************************************
  // supervisor full performance (bit 2 of the write) settles on the short interval, normal on the long one
  sslc_settle_timer #(
    .FAST_CYC(SETTLE_FULL_CYC),
    .SLOW_CYC(SETTLE_SLOW)
  ) u_low_settle (
    .clk(clk),
    .reset(reset),
    .start(wrLow),
    .fullPerf(pwdata[1+1]),
    .busy(lowSettle)
  );

  sslc_settle_timer #(
    .FAST_CYC(SETTLE_FULL_CYC),
    .SLOW_CYC(SETTLE_SLOW)
  ) u_high_settle (
    .clk(clk),
    .reset(reset),
    .start(wrHigh),
    .fullPerf(pwdata[1+1]),
    .busy(highSettle)
  );

  // ****************************************************************
  // unit states and wake timing
  // ****************************************************************
  // monitors have no keep bit and hold their state under manual control
  assign deep = (mode == MODE_SLEEP);
  assign coreSupvSt = sslc_perf(lowCtl.supvEnable, lowCtl.supvLpmKeep,
                                lowCtl.supvFullPerf, lowCtl.autoControl, deep);
  assign coreMonSt = sslc_perf(lowCtl.monEnable, 1'b1, lowCtl.monFullPerf,
                               lowCtl.autoControl, deep);
  assign supplySupvSt = sslc_perf(highCtl.supvEnable, highCtl.supvLpmKeep,
                                  highCtl.supvFullPerf, highCtl.autoControl, deep);
  assign supplyMonSt = sslc_perf(highCtl.monEnable, 1'b1, highCtl.monFullPerf,
                                 highCtl.autoControl, deep);

  // any core unit enabled in normal performance forces the slow wake
  assign wakeFast = !((lowCtl.supvEnable && !lowCtl.supvFullPerf) ||
                      (lowCtl.monEnable && !lowCtl.monFullPerf));

  // ****************************************************************
  // sleep sequencer
  // ****************************************************************
  assign sleepReq = wrSleep && (pwdata[SLP_LEVEL_LSB +: 2] != LEVEL_NONE);
  assign autoReq = isrReturn && sleepOnExit && (sleepLevel != LEVEL_NONE);
  assign enterSleep = (mode == MODE_ACTIVE) && (sleepReq || autoReq);

  // an interrupt in the entry cycle is latched, so none is lost
  always_ff @(posedge clk) begin
    if (reset || programReset) begin
      wakePending <= 1'b0;
    end else if (mode == MODE_SLEEP) begin
      wakePending <= 1'b0;
    end else if (enterSleep && wakeIrq) begin
      wakePending <= 1'b1;
    end
  end

  // mode and wake countdown; program reset overrides every state
  always_ff @(posedge clk) begin
    if (reset || programReset) begin
      mode <= MODE_ACTIVE;
      wakeCount <= '0;
    end else begin
      case (mode)
        MODE_ACTIVE: begin
          if (enterSleep) begin
            mode <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (wakeIrq || wakePending) begin
            mode <= MODE_WAKING;
            wakeCount <= wakeFast ? TIMER_W'(WAKE_FAST_CYC - 1) : TIMER_W'(WAKE_SLOW - 1);
          end
        end
        MODE_WAKING: begin
          if (wakeCount == '0) begin
            mode <= MODE_ACTIVE;
          end else begin
            wakeCount <= wakeCount - 1'b1;
          end
        end
        default: mode <= MODE_ACTIVE;
      endcase
    end
  end

  assign cpuHold = (mode != MODE_ACTIVE);
  assign deepSleep = deep;

  // ****************************************************************
  // events, reset requests and flags
  // ****************************************************************
  // supervisor and monitor trips are ignored while the unit is off or its comparator settles
  assign coreSupvEvt = trip.coreSupv && (coreSupvSt != PERF_OFF) && !lowSettle;
  assign coreMonEvt = trip.coreMon && (coreMonSt != PERF_OFF) && !lowSettle;
  assign supplySupvEvt = trip.supplySupv && (supplySupvSt != PERF_OFF) && !highSettle;
  assign supplyMonEvt = trip.supplyMon && (supplyMonSt != PERF_OFF) && !highSettle;
  assign ovpEvt = trip.overvolt && highCtl.ovpEnable && (supplyMonSt != PERF_OFF);

  // reset request is a registered one-cycle pulse per event cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      porRequest <= 1'b0;
    end else begin
      porRequest <= (coreSupvEvt && lowCtl.supvPorEnable) ||
                    (coreMonEvt && lowCtl.monPorEnable) ||
                    (supplySupvEvt && highCtl.supvPorEnable) ||
                    (supplyMonEvt && highCtl.monPorEnable) ||
                    ovpEvt;
    end
  end

  // events that do not reset set sticky flags instead, except supply monitor events while ovpEnable is set
  always_comb begin
    evtSet = '0;
    evtSet[FLG_CORE_SUPV] = coreSupvEvt && !lowCtl.supvPorEnable;
    evtSet[FLG_CORE_MON] = coreMonEvt && !lowCtl.monPorEnable;
    evtSet[FLG_SUPPLY_SUPV] = supplySupvEvt && !highCtl.supvPorEnable;
    evtSet[FLG_SUPPLY_MON] = supplyMonEvt && !highCtl.monPorEnable && !highCtl.ovpEnable;
    evtSet[FLG_EARLY_ENTRY] = enterSleep && (lowSettle || highSettle);
    evtSet[FLG_WAKE_DONE] = (mode == MODE_WAKING) && (wakeCount == '0);
  end

  // write one to clear; a set in the same cycle wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= '0;
    end else begin
      flags <= ((flags & ~(wrFlags ? pwdata[FLG_W-1:0] : '0)) | evtSet) & STICKY_BITS;
      flags[FLG_LOW_SETTLE] <= lowSettle;
      flags[FLG_HIGH_SETTLE] <= highSettle;
    end
  end

  assign irq = |(flags & mask & STICKY_BITS);

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam int FAST_MAX = WAKE_FAST_CYC + 1;

  chk_sw_entry: assert property (@(posedge clk) disable iff (reset)
    (mode == MODE_ACTIVE) && sleepReq && !programReset |=> deepSleep && cpuHold)
    else $error("software sleep request not taken");

  chk_auto_entry: assert property (@(posedge clk) disable iff (reset)
    (mode == MODE_ACTIVE) && isrReturn && sleepOnExit && (sleepLevel != LEVEL_NONE)
    && !programReset |=> deepSleep)
    else $error("sleep on isr exit not taken");

  chk_early_irq: assert property (@(posedge clk) disable iff (reset)
    enterSleep && wakeIrq && !programReset ##1 !programReset |=> mode == MODE_WAKING)
    else $error("interrupt at entry did not wake");

  chk_puc_recover: assert property (@(posedge clk) disable iff (reset)
    programReset |=> !cpuHold && !deepSleep)
    else $error("program reset did not restore active");

  chk_fast_wake: assert property (@(posedge clk) disable iff (reset || programReset)
    $rose(mode == MODE_WAKING) && wakeFast && $stable(lowCtl)
    |-> ##[1:FAST_MAX] !cpuHold)
    else $error("fast wake too long");

  chk_slow_select: assert property (@(posedge clk) disable iff (reset)
    (lowCtl.supvEnable && !lowCtl.supvFullPerf) || (lowCtl.monEnable && !lowCtl.monFullPerf)
    |-> !wakeFast)
    else $error("normal performance did not select slow wake");

  chk_slow_hold: assert property (@(posedge clk) disable iff (reset || programReset)
    $rose(mode == MODE_WAKING) && !wakeFast |-> cpuHold [*8])
    else $error("slow wake ended early");

  chk_supply_auto: assert property (@(posedge clk) disable iff (reset)
    deepSleep && highCtl.autoControl && !highCtl.monFullPerf |-> supplyMonSt == PERF_OFF)
    else $error("supply monitor active in deep sleep under auto control");

  chk_supply_drop: assert property (@(posedge clk) disable iff (reset)
    deepSleep && !highCtl.supvLpmKeep |-> supplySupvSt == PERF_OFF)
    else $error("supply supervisor kept in deep sleep");

  chk_ovp_por: assert property (@(posedge clk) disable iff (reset)
    trip.overvolt && highCtl.ovpEnable && !deepSleep && highCtl.monEnable |=> porRequest)
    else $error("overvoltage did not request reset");

  chk_core_event: assert property (@(posedge clk) disable iff (reset)
    coreSupvEvt && !lowCtl.supvPorEnable |=> flags[FLG_CORE_SUPV])
    else $error("core supervisor event lost");

  chk_state_off: assert property (@(posedge clk) disable iff (reset)
    !lowCtl.supvEnable |-> coreSupvSt == PERF_OFF)
    else $error("disabled core supervisor not off");

  chk_settle_set: assert property (@(posedge clk) disable iff (reset)
    wrLow |=> lowSettle ##1 flags[FLG_LOW_SETTLE])
    else $error("settle flag not raised by control write");

  cov_sleep_wake: cover property (@(posedge clk) disable iff (reset)
    deepSleep ##1 mode == MODE_WAKING);
  cov_early_irq: cover property (@(posedge clk) disable iff (reset)
    enterSleep && wakeIrq);
  cov_ovp: cover property (@(posedge clk) disable iff (reset) ovpEvt);
  cov_early_entry: cover property (@(posedge clk) disable iff (reset)
    evtSet[FLG_EARLY_ENTRY]);

endmodule
`default_nettype wire

/* File: tb/sslc_supervisor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sslc_supervisor_tb_top
  import sslc_pkg::*;
;
  // ****************************************************************
  // clock, reset and design under test
  // ****************************************************************
  // short slow counts keep the run brief
  localparam int SLOW = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wakeIrq = 1'b0;
  logic isrReturn = 1'b0;
  logic programReset = 1'b0;
  sslc_trip_s trip = '0;
  logic [31:0] prdata;
  logic pready, pslverr, cpuHold, deepSleep, porRequest, irq, wakeFast;
  int n_fail = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  sslc_supervisor #(.WAKE_SLOW(SLOW), .SETTLE_SLOW(SLOW)) dut_u (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakeIrq(wakeIrq), .isrReturn(isrReturn), .programReset(programReset), .trip(trip),
    .cpuHold(cpuHold), .deepSleep(deepSleep), .porRequest(porRequest), .irq(irq),
    .wakeFast(wakeFast)
  );

  // ****************************************************************
  // bench tasks and expectation functions
  // ****************************************************************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, entered just after a rising edge; one idle edge after it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      end_sim();
    end
    @(posedge clk);
  endtask

  // first read shows the flags the write raised; then poll until both read zero, bounded
  task automatic settle(input logic [1:0] first);
    logic [31:0] r;
    logic e;
    int k;
    k = 0;
    xfer(1'b0, OFS_FLAGS, 32'h0, r, e);
    chk("settle raised", {30'h0, first}, {30'h0, r[1:0]});
    do begin
      xfer(1'b0, OFS_FLAGS, 32'h0, r, e);
      k++;
    end while (r[1:0] !== 2'b00 && k < 300);
    chk("settle flags", 32'h0, {30'h0, r[1:0]});
  endtask

  // one comparator pulse; returns reset request seen the cycle after
  task automatic pulse(input logic [4:0] t, output logic p);
    trip <= t;
    @(posedge clk);
    trip <= 5'h00;
    @(posedge clk);
    p = porRequest;
  endtask

  function automatic logic [1:0] perf(input logic en, keep, fp, au, dp);
    if (!en) return 2'h0;
    if (!dp) return fp ? 2'h2 : 2'h1;
    if (!keep) return 2'h0;
    if (au) return fp ? 2'h1 : 2'h0;
    return fp ? 2'h2 : 2'h1;
  endfunction

  // monitors have no keep bit, so they always keep
  function automatic logic [3:0] side_st(input logic [8:0] c, input logic dp);
    return {perf(c[3], 1'b1, c[4], c[5], dp), perf(c[0], c[1], c[2], c[5], dp)};
  endfunction

  function automatic logic fast_exp(input logic [8:0] c);
    return (!c[0] || c[2]) && (!c[3] || c[4]);
  endfunction

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic e, p, ox, fw, wk;
    logic [8:0] lc, hc;
    logic [1:0] lv;
    int n;
    void'($urandom(67783));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    xfer(1'b0, OFS_LOW_CTL, 32'h0, r, e);
    chk("low ctl reset", 32'h041, r);
    xfer(1'b0, OFS_HIGH_CTL, 32'h0, r, e);
    chk("high ctl reset", 32'h041, r);
    xfer(1'b0, OFS_MASK, 32'h0, r, e);
    chk("mask reset", 32'h0, r);
    chk("wakeFast reset", 32'h0, {31'h0, wakeFast});
    xfer(1'b0, 8'h18, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    // random settings, first two are corner cases: fast then slow core, each with supply dropping off
    for (int i = 0; i < 8; i++) begin
      lc = (i == 0) ? 9'h005 : (i == 1) ? 9'h001 : 9'($urandom);
      hc = (i == 0) ? 9'h001 : (i == 1) ? 9'h02b : 9'($urandom);
      lv = 2'($urandom_range(3, 1));
      ox = (i < 2) ? 1'b1 : (i == 2) ? 1'b0 : 1'($urandom);
      wk = (i == 0) || 1'($urandom);
      fw = fast_exp(lc);
      xfer(1'b1, OFS_LOW_CTL, {23'h0, lc}, r, e);
      xfer(1'b1, OFS_HIGH_CTL, {23'h0, hc}, r, e);
      settle(2'b11);
      chk("wakeFast", {31'h0, fw}, {31'h0, wakeFast});
      xfer(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("status active", {21'h0, 2'h0, fw, side_st(hc, 1'b0), side_st(lc, 1'b0)}, r);
      xfer(1'b1, OFS_SLEEP, {29'h0, ox, lv}, r, e);
      chk("sleep entry", 32'h1, {31'h0, deepSleep});
      xfer(1'b0, OFS_STATUS, 32'h0, r, e);
      chk("status deep", {21'h0, 2'h1, fw, side_st(hc, 1'b1), side_st(lc, 1'b1)}, r);
      // interrupt only a few cycles after entry must still wake
      wakeIrq <= 1'b1;
      @(posedge clk);
      wakeIrq <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (cpuHold === 1'b1 && n < 20000);
      n = fw ? n - WAKE_FAST_CYC : n - SLOW;
      chk("wake length", 32'h1, {31'h0, n >= 0 && n <= 2});
      // an interrupt in the very entry cycle must still wake
      isrReturn <= 1'b1;
      wakeIrq <= wk;
      @(posedge clk);
      isrReturn <= 1'b0;
      wakeIrq <= 1'b0;
      @(posedge clk);
      chk("sleep on exit", {31'h0, ox}, {31'h0, deepSleep});
      @(posedge clk);
      chk("entry irq wake", {30'h0, ox && !wk, ox}, {30'h0, deepSleep, cpuHold});
      programReset <= 1'b1;
      @(posedge clk);
      programReset <= 1'b0;
      @(posedge clk);
      chk("prog reset hold", 32'h0, {30'h0, deepSleep, cpuHold});
    end
    // events: reset request versus sticky flag and interrupt
    xfer(1'b1, OFS_LOW_CTL, 32'h041, r, e);
    settle(2'b01);
    pulse(5'h01, p);
    chk("core por", 32'h1, {31'h0, p});
    xfer(1'b1, OFS_FLAGS, 32'h0fc, r, e);
    xfer(1'b1, OFS_LOW_CTL, 32'h00b, r, e);
    settle(2'b01);
    pulse(5'h03, p);
    chk("core no por", 32'h0, {31'h0, p});
    xfer(1'b0, OFS_FLAGS, 32'h0, r, e);
    chk("event flags", 32'h0c, r);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, OFS_MASK, 32'h0c, r, e);
    chk("irq raised", 32'h1, {31'h0, irq});
    xfer(1'b1, OFS_FLAGS, 32'h04, r, e);
    xfer(1'b1, OFS_MASK, 32'h04, r, e);
    chk("irq after clear", 32'h0, {31'h0, irq});
    xfer(1'b0, OFS_FLAGS, 32'h0, r, e);
    chk("one flag left", 32'h08, r);
    // overvoltage: only with protection on does a trip reset
    xfer(1'b1, OFS_HIGH_CTL, 32'h108, r, e);
    settle(2'b10);
    pulse(5'h10, p);
    chk("ovp por", 32'h1, {31'h0, p});
    xfer(1'b1, OFS_HIGH_CTL, 32'h008, r, e);
    settle(2'b10);
    pulse(5'h10, p);
    chk("ovp off", 32'h0, {31'h0, p});
    end_sim();
  end
endmodule
`default_nettype wire
